/* File: hw/pwm_pkg.sv */
// constants, field layouts and carriers for the enhanced pwm generator
// assumes one clock at the oscillator rate and a classic wishbone master
// Overview of operation
// - duty held in shadow plus two-bit latch
// - clear pin when shadow equals extended timer
// - duty beyond period never clears pin
// - resolution is log2 of fosc over fpwm
// - prescaler divides by one, four or sixteen
// - only first unit supports auto-shutdown
// - up to four outputs, single output compatible
// - output mode steers pins, module mode sets polarity
// - control copies load at period boundary
// - dead-band loads at first duty/period boundary
// - enhanced output lags by one instruction cycle
// - period is (limit+1)*4*tosc*prescale
// - timer clears after matching period limit
// - boundary sets pin unless duty zero
// - boundary copies duty into shadow register
// - postscaler never changes pwm frequency
package pwm_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned TOSC_PER_TCY = 4; // oscillator periods per instruction cycle
  localparam logic [1:0] TCY_LAST = 2'(TOSC_PER_TCY - 1);
  localparam int unsigned LAG_STAGES = TOSC_PER_TCY;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h00;
  localparam logic [7:0] OFS_DUTY_SETTING = 8'h04;
  localparam logic [7:0] OFS_UNIT_CONTROL = 8'h08;
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_DEADBAND = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_DUTY_SHADOW = 8'h18;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
  localparam logic [7:0] RST_DUTY_SETTING = 8'h00;
  localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
  localparam logic [6:0] RST_TIMER_CONTROL = 7'h00;
  localparam logic [6:0] RST_DEADBAND = 7'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned STAT_COUNT_POS = 0;  // timer count, 8 bits
  localparam int unsigned STAT_PINS_POS = 8;   // pin levels a..d, 4 bits
  localparam int unsigned STAT_RAW_POS = 12;   // unlagged pwm level
  localparam int unsigned STAT_UPD_POS = 16;   // postscaled update count, 8 bits

  // prescale select codes
  localparam logic [1:0] PRESC_1 = 2'h0;
  localparam logic [1:0] PRESC_4 = 2'h1;
  localparam logic [1:0] PRESC_16 = 2'h2;

  // output configuration codes
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FULL_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_FULL_REV = 2'h3;
  localparam logic [1:0] MODE_PWM = 2'h3; // upper bits of module mode

  // compare unit control word, bit 7 down to 0
  typedef struct packed {
    logic [1:0] output_config_select;
    logic [1:0] duty_low;
    logic [3:0] module_mode_select;
  } unit_control_t;

  // period timer control word, bit 6 down to 0
  typedef struct packed {
    logic [3:0] postscale;
    logic timer_on;
    logic [1:0] prescale_sel;
  } timer_control_t;

endpackage : pwm_pkg

/* File: hw/pwm_timebase.sv */
// instruction-cycle divider, period timer prescaler and fine count
// assumes the clock is the oscillator and ce_in gates every edge
`timescale 1ns/100ps
module pwm_timebase
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control
  input wire logic timer_on_in,
  input wire logic [1:0] prescale_sel_in,
  // timing outputs
  output logic inc_tick_out,
  output logic [1:0] fine_out
);

  logic [1:0] q_reg; // quadrature phase within instruction cycle
  logic [1:0] q_next;
  logic [3:0] presc_reg; // prescaler count
  logic [3:0] presc_next;
  logic tcy_tick; // last phase of an instruction cycle
  logic presc_wrap; // prescaler at its last count

  // next values of divider and prescaler
  always_comb
  begin
    tcy_tick = (q_reg == pwm_pkg::TCY_LAST);
    q_next = q_reg + 2'h1;
    case (prescale_sel_in)
      pwm_pkg::PRESC_1: presc_wrap = 1'b1;
      pwm_pkg::PRESC_4: presc_wrap = (presc_reg[1:0] == 2'h3);
      default: presc_wrap = (presc_reg == 4'hF);
    endcase
    presc_next = presc_reg;
    if (!timer_on_in)
    begin
      presc_next = 4'h0; // stopped timer restarts from a clean count
    end
    else if (tcy_tick)
    begin
      presc_next = presc_wrap ? 4'h0 : presc_reg + 4'h1;
    end
    inc_tick_out = timer_on_in & tcy_tick & presc_wrap;
    // low two bits of the extended compare value
    case (prescale_sel_in)
      pwm_pkg::PRESC_1: fine_out = q_reg;
      pwm_pkg::PRESC_4: fine_out = presc_reg[1:0];
      default: fine_out = presc_reg[3:2];
    endcase
  end

  // register divider state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q_reg <= 2'h0;
      presc_reg <= 4'h0;
    end
    else if (ce_in)
    begin
      q_reg <= q_next;
      presc_reg <= presc_next;
    end
  end

endmodule : pwm_timebase

/* File: hw/pwm_pin_stage.sv */
// one output pin: rising-edge dead band, polarity and enable
// assumes raw level and controls are synchronous to clk_in
`timescale 1ns/100ps
module pwm_pin_stage
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // controls
  input wire logic raw_in,
  input wire logic [6:0] delay_in,
  input wire logic invert_in,
  input wire logic enable_in,
  input wire logic shutdown_in,
  // pin level
  output logic pin_out
);

  logic [6:0] db_reg; // dead-band countdown
  logic [6:0] db_next;
  logic raw_d_reg; // previous raw level, finds rising edges
  logic pin_reg;
  logic pin_next;
  logic active;

  // next dead-band count and pin level
  always_comb
  begin
    db_next = db_reg;
    if (raw_in && !raw_d_reg)
    begin
      db_next = delay_in; // hold off the active edge
    end
    else if (db_reg != 7'h00)
    begin
      db_next = db_reg - 7'h01;
    end
    active = raw_in & (db_next == 7'h00) & ~shutdown_in;
    if (!enable_in)
    begin
      pin_next = 1'b0; // not a pwm pin
    end
    else
    begin
      pin_next = active ^ invert_in;
    end
  end

  // register stage state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      db_reg <= 7'h00;
      raw_d_reg <= 1'b0;
      pin_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      db_reg <= db_next;
      raw_d_reg <= raw_in;
      pin_reg <= pin_next;
    end
  end

  assign pin_out = pin_reg;

endmodule : pwm_pin_stage

/* File: hw/enhanced_pwm_generator.sv */
// enhanced pwm generator: wishbone registers, period timer, duty compare,
// output steering over four pins
// assumes a classic wishbone master on the same clock as the oscillator
`timescale 1ns/100ps
module enhanced_pwm_generator
(
  // clock, enable and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  // fault input, forces pins inactive
  input wire logic shutdown_in,
  // pwm pins
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d
);

  // ****************************************
  // declarations
  // ****************************************
  // software-visible registers
  logic [7:0] period_limit_reg;
  logic [7:0] period_limit_next;
  logic [7:0] duty_setting_reg; // upper eight duty bits
  logic [7:0] duty_setting_next;
  pwm_pkg::unit_control_t ctl_reg; // compare_unit_control
  pwm_pkg::unit_control_t ctl_next;
  pwm_pkg::timer_control_t tcon_reg; // period_timer_control
  pwm_pkg::timer_control_t tcon_next;
  logic [6:0] deadband_delay_reg;
  logic [6:0] deadband_delay_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  // pwm core state
  logic [7:0] period_timer_count_reg;
  logic [7:0] period_timer_count_next;
  logic [9:0] duty_shadow_reg; // shadow with two-bit latch
  logic [9:0] duty_shadow_next;
  pwm_pkg::unit_control_t ctl_active_reg; // copy used by steering
  pwm_pkg::unit_control_t ctl_active_next;
  logic [6:0] db_active_reg; // dead band in use
  logic [6:0] db_active_next;
  logic db_pending_reg; // dead band written, not yet loaded
  logic db_pending_next;
  logic pwm_raw_reg;
  logic pwm_raw_next;
  logic [pwm_pkg::LAG_STAGES-1:0] lag_reg; // one instruction cycle of delay
  logic [pwm_pkg::LAG_STAGES-1:0] lag_next;
  logic [3:0] post_cnt_reg; // postscaler
  logic [3:0] post_cnt_next;
  logic [7:0] upd_cnt_reg; // slow update events
  logic [7:0] upd_cnt_next;
  // combinational helpers
  logic take; // new bus request
  logic wr_en;
  logic inc_tick;
  logic [1:0] fine;
  logic boundary; // period boundary this cycle
  logic duty_match;
  logic pwm_on;
  logic lagged;
  logic [3:0] raw_pins;
  logic [3:0] inv_pins;
  logic [3:0] en_pins;
  logic [3:0] dbe_pins;
  logic [3:0] pins;

  // ****************************************
  // wishbone register file
  // ****************************************
  assign take = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign wr_en = take & wb_we_in & wb_sel_in[0];

  // next register values and read data
  always_comb
  begin
    period_limit_next = period_limit_reg;
    duty_setting_next = duty_setting_reg;
    ctl_next = ctl_reg;
    tcon_next = tcon_reg;
    deadband_delay_next = deadband_delay_reg;
    ack_next = take; // answer one cycle after the request
    rdat_next = rdat_reg;
    // writes land only in lane 0
    if (wr_en)
    begin
      case (wb_adr_in)
        pwm_pkg::OFS_PERIOD_LIMIT: period_limit_next = wb_dat_in[7:0];
        pwm_pkg::OFS_DUTY_SETTING: duty_setting_next = wb_dat_in[7:0];
        pwm_pkg::OFS_UNIT_CONTROL: ctl_next = pwm_pkg::unit_control_t'(wb_dat_in[7:0]);
        pwm_pkg::OFS_TIMER_CONTROL: tcon_next = pwm_pkg::timer_control_t'(wb_dat_in[6:0]);
        pwm_pkg::OFS_DEADBAND: deadband_delay_next = wb_dat_in[6:0];
        default: ; // read-only or unmapped: ignored
      endcase
    end
    // read data, unmapped reads zero
    if (take)
    begin
      rdat_next = 32'h0000_0000;
      case (wb_adr_in)
        pwm_pkg::OFS_PERIOD_LIMIT: rdat_next[7:0] = period_limit_reg;
        pwm_pkg::OFS_DUTY_SETTING: rdat_next[7:0] = duty_setting_reg;
        pwm_pkg::OFS_UNIT_CONTROL: rdat_next[7:0] = ctl_reg;
        pwm_pkg::OFS_TIMER_CONTROL: rdat_next[6:0] = tcon_reg;
        pwm_pkg::OFS_DEADBAND: rdat_next[6:0] = deadband_delay_reg;
        pwm_pkg::OFS_STATUS:
        begin
          rdat_next[pwm_pkg::STAT_COUNT_POS +: 8] = period_timer_count_reg;
          rdat_next[pwm_pkg::STAT_PINS_POS +: 4] = pins;
          rdat_next[pwm_pkg::STAT_RAW_POS] = pwm_raw_reg;
          rdat_next[pwm_pkg::STAT_UPD_POS +: 8] = upd_cnt_reg;
        end
        pwm_pkg::OFS_DUTY_SHADOW: rdat_next[9:0] = duty_shadow_reg;
        default: rdat_next = 32'h0000_0000;
      endcase
    end
  end

  // register the software-visible state
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      period_limit_reg <= pwm_pkg::RST_PERIOD_LIMIT;
      duty_setting_reg <= pwm_pkg::RST_DUTY_SETTING;
      ctl_reg <= pwm_pkg::unit_control_t'(pwm_pkg::RST_UNIT_CONTROL);
      tcon_reg <= pwm_pkg::timer_control_t'(pwm_pkg::RST_TIMER_CONTROL);
      deadband_delay_reg <= pwm_pkg::RST_DEADBAND;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      period_limit_reg <= period_limit_next;
      duty_setting_reg <= duty_setting_next;
      ctl_reg <= ctl_next;
      tcon_reg <= tcon_next;
      deadband_delay_reg <= deadband_delay_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdat_reg;

  // ****************************************
  // time base
  // ****************************************
  // divider, prescaler and fine count
  pwm_timebase u_timebase
  (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .timer_on_in(tcon_reg.timer_on),
    .prescale_sel_in(tcon_reg.prescale_sel),
    .inc_tick_out(inc_tick),
    .fine_out(fine)
  );

  // ****************************************
  // period timer, compare and buffering
  // ****************************************
  // timer wraps on the increment after it equals the limit
  assign boundary = inc_tick & (period_timer_count_reg == period_limit_reg);
  // ten-bit compare gives log2(fosc/fpwm) bits at best
  assign duty_match = ({period_timer_count_reg, fine} == duty_shadow_reg);
  assign pwm_on = (ctl_active_reg.module_mode_select[3:2] == pwm_pkg::MODE_PWM);

  // next timer, shadow, active copies and raw level
  always_comb
  begin
    period_timer_count_next = period_timer_count_reg;
    duty_shadow_next = duty_shadow_reg;
    ctl_active_next = ctl_active_reg;
    db_active_next = db_active_reg;
    db_pending_next = db_pending_reg | (wr_en & (wb_adr_in == pwm_pkg::OFS_DEADBAND));
    pwm_raw_next = pwm_raw_reg;
    post_cnt_next = post_cnt_reg;
    upd_cnt_next = upd_cnt_reg;
    if (boundary)
    begin
      period_timer_count_next = 8'h00;
      duty_shadow_next = {duty_setting_reg, ctl_reg.duty_low};
      ctl_active_next = ctl_reg;
      // zero duty keeps the pin low
      pwm_raw_next = ({duty_setting_reg, ctl_reg.duty_low} != 10'h000);
      // postscaler only paces update events
      if (post_cnt_reg == tcon_reg.postscale)
      begin
        post_cnt_next = 4'h0;
        upd_cnt_next = upd_cnt_reg + 8'h01;
      end
      else
      begin
        post_cnt_next = post_cnt_reg + 4'h1;
      end
    end
    else
    begin
      if (inc_tick)
      begin
        period_timer_count_next = period_timer_count_reg + 8'h01;
      end
      // a duty past the limit never matches
      if (duty_match)
      begin
        pwm_raw_next = 1'b0;
      end
    end
    // dead band loads at whichever boundary comes first
    if (db_pending_reg && (boundary || (duty_match && pwm_raw_reg)))
    begin
      db_active_next = deadband_delay_reg;
      // a write landing on the load cycle stays pending, so the newer value is not lost
      db_pending_next = wr_en & (wb_adr_in == pwm_pkg::OFS_DEADBAND);
    end
    // buffered output trails by one instruction cycle
    lag_next = {lag_reg[pwm_pkg::LAG_STAGES-2:0], pwm_raw_reg};
  end

  // register the pwm core
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      period_timer_count_reg <= 8'h00;
      duty_shadow_reg <= 10'h000;
      ctl_active_reg <= pwm_pkg::unit_control_t'(pwm_pkg::RST_UNIT_CONTROL);
      db_active_reg <= pwm_pkg::RST_DEADBAND;
      db_pending_reg <= 1'b0;
      pwm_raw_reg <= 1'b0;
      lag_reg <= '0;
      post_cnt_reg <= 4'h0;
      upd_cnt_reg <= 8'h00;
    end
    else if (ce_in)
    begin
      period_timer_count_reg <= period_timer_count_next;
      duty_shadow_reg <= duty_shadow_next;
      ctl_active_reg <= ctl_active_next;
      db_active_reg <= db_active_next;
      db_pending_reg <= db_pending_next;
      pwm_raw_reg <= pwm_raw_next;
      lag_reg <= lag_next;
      post_cnt_reg <= post_cnt_next;
      upd_cnt_reg <= upd_cnt_next;
    end
  end

  // ****************************************
  // output steering and polarity
  // ****************************************
  assign lagged = lag_reg[pwm_pkg::LAG_STAGES-1];

  // levels, polarity and enables per pin
  always_comb
  begin
    raw_pins = 4'h0;
    en_pins = 4'h0;
    dbe_pins = 4'h0;
    case (ctl_active_reg.output_config_select)
      pwm_pkg::CFG_SINGLE:
      begin
        raw_pins = {3'h0, lagged}; // a only, standard behaviour
        en_pins = 4'h1;
      end
      pwm_pkg::CFG_FULL_FWD:
      begin
        raw_pins = {lagged, 2'h0, 1'b1}; // a active, d modulated
        en_pins = 4'hF;
      end
      pwm_pkg::CFG_HALF:
      begin
        raw_pins = {2'h0, ~lagged, lagged}; // complementary a and b
        en_pins = 4'h3;
        dbe_pins = 4'h3;
      end
      pwm_pkg::CFG_FULL_REV:
      begin
        raw_pins = {1'b0, 1'b1, lagged, 1'b0}; // c active, b modulated
        en_pins = 4'hF;
      end
      default:
      begin
        raw_pins = 4'h0;
      end
    endcase
    if (!pwm_on)
    begin
      en_pins = 4'h0;
    end
    // bit 1 inverts a and c, bit 0 inverts b and d
    inv_pins = {ctl_active_reg.module_mode_select[0], ctl_active_reg.module_mode_select[1],
                ctl_active_reg.module_mode_select[0], ctl_active_reg.module_mode_select[1]};
  end

  // one pin stage per output
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
      pwm_pin_stage u_pin
      (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .raw_in(raw_pins[gi]),
        .delay_in(dbe_pins[gi] ? db_active_reg : 7'h00),
        .invert_in(inv_pins[gi]),
        .enable_in(en_pins[gi]),
        .shutdown_in(shutdown_in),
        .pin_out(pins[gi])
      );
    end
  endgenerate

  assign pwm_out_a = pins[0];
  assign pwm_out_b = pins[1];
  assign pwm_out_c = pins[2];
  assign pwm_out_d = pins[3];

endmodule : enhanced_pwm_generator

/* File: tb/enhanced_pwm_generator_assertions.sv */
// timing checks on the pwm generator's bus and pins
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
module pwm_gen_checker
(
  // clock, enable and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  // pins
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic pwm_out_c,
  input wire logic pwm_out_d
);
  // ****************************************
  // common timing
  // ****************************************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic req; // a request is on the bus
  assign req = wb_cyc_in && wb_stb_in;
  logic [3:0] pins; // all four pin levels
  assign pins = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};

  // ****************************************
  // bus answers
  // ****************************************
  ack_answer_a: assert property (req && !wb_ack_out && ce_in |=> wb_ack_out)
    else $error("request not answered in the next cycle");
  ack_pulse_a: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!req && ce_in |=> !wb_ack_out)
    else $error("ack without request");
  dat_hold_a: assert property (!req && ce_in |=> $stable(wb_dat_out))
    else $error("read data moved without request");
  unmapped_zero_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in >= 8'h1C |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h00 |-> wb_dat_out[31:8] == 24'h0)
    else $error("period limit upper bits not zero");

  // ****************************************
  // pin timing
  // ****************************************
  reset_pins_a: assert property ($past(rst_in) |-> pins == 4'h0 && !wb_ack_out)
    else $error("pins or ack active right after reset");
  period_min_a: assert property ($rose(pwm_out_a) |=> !$rose(pwm_out_a) [*3])
    else $error("pin a rises faster than the shortest period");
  freeze_a: assert property (!ce_in |=> $stable(pins) && $stable(wb_ack_out))
    else $error("state moved while clock enable low");
endmodule : pwm_gen_checker

bind enhanced_pwm_generator pwm_gen_checker u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
  .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d));

/* File: tb/test_enhanced_pwm_generator.sv */
// self-checking bench for the enhanced pwm generator
// assumes the package, design and checker files are compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD at %0t got %0h exp %0h", $time, (g), (e)); end end
module test_enhanced_pwm_generator;
  // ****************************************
  // signals
  // ****************************************
  logic ref_clk_in = 1'h0; // oscillator clock
  logic rst_in = 1'h1;
  logic ce_in = 1'h1;
  logic wb_cyc_in = 1'h0;
  logic wb_stb_in = 1'h0;
  logic wb_we_in = 1'h0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic wb_ack_out;
  logic [31:0] wb_dat_out;
  logic shutdown_in = 1'h0;
  logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
  int n_mismatch = 0;
  int comparisons = 0;
  int cnt [4]; // high cycles per pin in a window
  logic [31:0] rd; // last word read

  // clock at 25 MHz
  initial forever #20 ref_clk_in = ~ref_clk_in;

  enhanced_pwm_generator DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .shutdown_in(shutdown_in), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
    .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d));

  // ****************************************
  // bus and measuring tasks
  // ****************************************
  // one classic cycle, held until ack is sampled
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] wd);
    int n = 0;
    @(posedge ref_clk_in);
    wb_cyc_in <= 1'h1;
    wb_stb_in <= 1'h1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_sel_in <= sel;
    wb_dat_in <= wd;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (wb_ack_out !== 1'h1 && n < 50);
    rd = wb_dat_out;
    `CHK(wb_ack_out, 1'h1)
    wb_cyc_in <= 1'h0;
    wb_stb_in <= 1'h0;
  endtask : wb_cycle

  // write one register
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    wb_cycle(1'h1, adr, 4'h1, wd);
  endtask : wr

  // read one register and compare
  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb_cycle(1'h0, adr, 4'hF, 32'h0);
    `CHK(rd, exp)
  endtask : rdchk

  // configure in the documented software order
  task automatic setup(input logic [9:0] duty, input logic [1:0] cfg, input logic [3:0] mode,
                       input logic [6:0] tctl);
    wr(pwm_pkg::OFS_PERIOD_LIMIT, 32'h9);
    wr(pwm_pkg::OFS_DUTY_SETTING, {24'h0, duty[9:2]});
    wr(pwm_pkg::OFS_UNIT_CONTROL, {24'h0, cfg, duty[1:0], 4'h0});
    wr(pwm_pkg::OFS_TIMER_CONTROL, {25'h0, tctl});
    wr(pwm_pkg::OFS_UNIT_CONTROL, {24'h0, cfg, duty[1:0], mode});
  endtask : setup

  // count high cycles of each pin over a window
  task automatic win_count(input int win);
    cnt = '{0, 0, 0, 0};
    repeat (win)
    begin
      @(negedge ref_clk_in);
      cnt[0] += int'(pwm_out_a === 1'h1);
      cnt[1] += int'(pwm_out_b === 1'h1);
      cnt[2] += int'(pwm_out_c === 1'h1);
      cnt[3] += int'(pwm_out_d === 1'h1);
    end
  endtask : win_count

  // rise-to-rise period and high time of pin a
  task automatic period_a(output int per, output int hi);
    int n = 0;
    per = 0;
    hi = 0;
    while (pwm_out_a !== 1'h0 && n < 3000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    while (pwm_out_a !== 1'h1 && n < 3000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    per = n; // cycle count at the first rise
    while (pwm_out_a === 1'h1 && n < 3000)
    begin
      @(negedge ref_clk_in);
      n++;
      hi++;
    end
    while (pwm_out_a !== 1'h1 && n < 3000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    per = n - per;
  endtask : period_a

  // ****************************************
  // scenarios
  // ****************************************
  // reset values, refused writes, unmapped read
  task automatic t_regs;
    rdchk(pwm_pkg::OFS_PERIOD_LIMIT, 32'hFF);
    rdchk(pwm_pkg::OFS_DUTY_SETTING, 32'h0);
    rdchk(pwm_pkg::OFS_UNIT_CONTROL, 32'h0);
    rdchk(pwm_pkg::OFS_TIMER_CONTROL, 32'h0);
    rdchk(pwm_pkg::OFS_DEADBAND, 32'h0);
    rdchk(8'h40, 32'h0);
    wb_cycle(1'h1, pwm_pkg::OFS_PERIOD_LIMIT, 4'h0, 32'h12);
    rdchk(pwm_pkg::OFS_PERIOD_LIMIT, 32'hFF);
    wr(pwm_pkg::OFS_DUTY_SHADOW, 32'h3FF);
    rdchk(pwm_pkg::OFS_DUTY_SHADOW, 32'h0);
    $display("test regs done");
  endtask : t_regs

  // period and high time at each prescale ratio, postscaler set
  task automatic t_presc;
    logic [1:0] code [3] = '{pwm_pkg::PRESC_1, pwm_pkg::PRESC_4, pwm_pkg::PRESC_16};
    int fac [3] = '{1, 4, 16};
    int per;
    int hi;
    for (int i = 0; i < 3; i++)
    begin
      setup(10'h016, pwm_pkg::CFG_SINGLE, 4'hC, {4'hF, 1'h1, code[i]});
      period_a(per, hi);
      period_a(per, hi);
      `CHK(per, 40 * fac[i])
      // the pin drops on the edge after the duty match is first seen
      `CHK(hi, 22 * fac[i] + 1)
      rdchk(pwm_pkg::OFS_DUTY_SHADOW, 32'h16);
    end
    $display("test prescale done");
  endtask : t_presc

  // duty beyond the period and zero duty
  task automatic t_limits;
    setup(10'h3FF, pwm_pkg::CFG_SINGLE, 4'hC, 7'h04);
    repeat (120) @(posedge ref_clk_in);
    win_count(80);
    `CHK(cnt[0], 80)
    setup(10'h000, pwm_pkg::CFG_SINGLE, 4'hC, 7'h04);
    repeat (120) @(posedge ref_clk_in);
    win_count(80);
    `CHK(cnt[0], 0)
    $display("test limits done");
  endtask : t_limits

  // every output configuration and both polarities
  task automatic t_steer;
    logic [1:0] cf [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
    logic [3:0] md [6] = '{4'hC, 4'hC, 4'hC, 4'hC, 4'hF, 4'hF};
    int ex [6][4] = '{'{11, 0, 0, 0}, '{40, 0, 0, 11}, '{11, 29, 0, 0}, '{0, 11, 40, 0},
                      '{29, 0, 0, 0}, '{29, 11, 0, 0}};
    for (int i = 0; i < 6; i++)
    begin
      setup(10'h00A, cf[i], md[i], 7'h04);
      repeat (120) @(posedge ref_clk_in);
      win_count(40);
      for (int j = 0; j < 4; j++)
        `CHK(cnt[j], ex[i][j])
    end
    wr(pwm_pkg::OFS_DEADBAND, 32'h4);
    repeat (120) @(posedge ref_clk_in);
    win_count(40);
    // dead band delays the active edge, so active-low pins stay high longer
    `CHK(cnt[0], 33)
    `CHK(cnt[1], 15)
    wr(pwm_pkg::OFS_DEADBAND, 32'h0);
    $display("test steering done");
  endtask : t_steer

  // fault shutdown and a clock enable pause
  task automatic t_shut;
    setup(10'h00A, pwm_pkg::CFG_SINGLE, 4'hC, 7'h04);
    repeat (120) @(posedge ref_clk_in);
    shutdown_in <= 1'h1;
    repeat (20) @(posedge ref_clk_in);
    win_count(40);
    `CHK(cnt[0], 0)
    @(posedge ref_clk_in);
    shutdown_in <= 1'h0;
    ce_in <= 1'h0;
    repeat (8) @(posedge ref_clk_in);
    ce_in <= 1'h1;
    $display("test shutdown done");
  endtask : t_shut

  // ****************************************
  // run control
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    t_regs;
    t_presc;
    t_limits;
    t_steer;
    t_shut;
    wrap_up;
  end

  // watchdog, far beyond the expected run
  initial
  begin
    repeat (40000) @(posedge ref_clk_in);
    n_mismatch++;
    wrap_up;
  end
endmodule : test_enhanced_pwm_generator
